// file: design/rsdc_defines.vh
// register offsets, field positions and reset values of the receive synthesizer config bank
`ifndef RSDC_DEFINES_VH
`define RSDC_DEFINES_VH
`define RSDC_ADDR_OCTAVE 8'hC0
`define RSDC_ADDR_MAIN_HIGH 8'hC1
`define RSDC_ADDR_MAIN_LOW 8'hC2
`define RSDC_ADDR_FRAC_UPPER 8'hC3
`define RSDC_ADDR_FRAC_MIDDLE 8'hC4
`define RSDC_ADDR_FRAC_LOWER 8'hC5
`define RSDC_ADDR_WINDOW_CTRL 8'hC6
`define RSDC_ADDR_LOSS_CTRL 8'hD1
`define RSDC_RST_OCTAVE 8'h00
`define RSDC_RST_MAIN_HIGH 8'h01
`define RSDC_RST_MAIN_LOW 8'h00
`define RSDC_RST_FRAC_UPPER 8'h80
`define RSDC_RST_FRAC_MIDDLE 8'h00
`define RSDC_RST_FRAC_LOWER 8'h00
`define RSDC_RST_WINDOW_CTRL 8'h0C
`define RSDC_RST_LOSS_CTRL 8'h0D
`define RSDC_MASK_OCTAVE 8'h07
`define RSDC_MASK_MAIN_HIGH 8'h01
`define RSDC_MASK_FRAC_UPPER 8'hBF
`define RSDC_MASK_WINDOW_CTRL 8'h3F
`define RSDC_MASK_LOSS_CTRL 8'hFF
`define RSDC_BIT_INTEGER_ONLY 7
`define RSDC_BIT_MANUAL_WINDOW 3
`define RSDC_BIT_WINDOW_SOURCE 4
`define RSDC_BIT_AUTO_WINDOW 5
`define RSDC_BIT_LOSS_ENABLE 0
`define RSDC_WIN_2000PPM 3'h3
`define RSDC_WIN_1000PPM 3'h4
`define RSDC_WIN_500PPM 3'h5
`define RSDC_WIN_250PPM 3'h6
`define RSDC_PPM_ZERO 12'h000
`define RSDC_PPM_2000 12'h7D0
`define RSDC_PPM_1000 12'h3E8
`define RSDC_PPM_500 12'h1F4
`define RSDC_PPM_250 12'h0FA
`endif

// file: design/rsdc_config_regs.v
// receive synthesizer divider and recovery window configuration register bank
`timescale 1ns/1ns
`default_nettype none
`include "rsdc_defines.vh"

module rsdc_config_regs (
  input wire core_clk,
  input wire rst,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wr_data,
  output reg [7:0] reg_rd_data,
  output reg reg_rd_hit,
  input wire window_select_pin,
  output reg [6:0] octave_ratio,
  output reg [8:0] main_ratio,
  output reg [21:0] fraction_value,
  output reg no_fraction_flag,
  output reg [11:0] window_ppm,
  output reg window_manual_active,
  output reg auto_window_enable,
  output reg signal_loss_detect_enable
);

  localparam REG_COUNT = 8;
  localparam IDX_OCTAVE = 0;
  localparam IDX_MAIN_HIGH = 1;
  localparam IDX_MAIN_LOW = 2;
  localparam IDX_FRAC_UPPER = 3;
  localparam IDX_FRAC_MIDDLE = 4;
  localparam IDX_FRAC_LOWER = 5;
  localparam IDX_WINDOW_CTRL = 6;
  localparam IDX_LOSS_CTRL = 7;

  // reset levels of the decoded outputs follow the register reset values
  localparam [6:0] OCTAVE_RATIO_RST = 7'h01;
  localparam [8:0] MAIN_RATIO_RST = 9'h100;
  localparam [6:0] OCTAVE_RATIO_MAX = 7'h40;

  // all eight stored bytes side by side, one slice per register
  wire [8*REG_COUNT-1:0] bank_flat;
  wire [REG_COUNT-1:0] addr_sel;
  wire [REG_COUNT-1:0] wr_sel;
  wire [REG_COUNT-1:0] rd_sel;
  wire [7:0] octave_byte;
  wire [7:0] main_high_byte;
  wire [7:0] main_low_byte;
  wire [7:0] frac_upper_byte;
  wire [7:0] frac_middle_byte;
  wire [7:0] frac_lower_byte;
  wire [7:0] window_ctrl_byte;
  wire [7:0] loss_ctrl_byte;
  wire [2:0] octave_ratio_code;
  wire main_ratio_top_bit;
  wire [7:0] main_ratio_low_byte;
  wire [5:0] fraction_upper_bits;
  wire [7:0] fraction_middle_bits;
  wire [7:0] fraction_lower_bits;
  wire integer_only_select;
  wire [2:0] window_size_code;
  wire manual_window_select;
  wire window_control_source;
  wire auto_window_field;
  wire loss_enable_field;

  reg [7:0] rd_data_d;
  reg rd_hit_d;
  reg mode_sel;
  reg [6:0] octave_ratio_d;
  reg [8:0] main_ratio_d;
  reg [21:0] fraction_value_d;
  reg [11:0] window_ppm_d;
  integer ri;

  // one-hot register select; shared by the write and the read path
  function [REG_COUNT-1:0] rsdc_sel_of;
    input [7:0] addr;
    begin
      case (addr)
        `RSDC_ADDR_OCTAVE: rsdc_sel_of = 8'h01;
        `RSDC_ADDR_MAIN_HIGH: rsdc_sel_of = 8'h02;
        `RSDC_ADDR_MAIN_LOW: rsdc_sel_of = 8'h04;
        `RSDC_ADDR_FRAC_UPPER: rsdc_sel_of = 8'h08;
        `RSDC_ADDR_FRAC_MIDDLE: rsdc_sel_of = 8'h10;
        `RSDC_ADDR_FRAC_LOWER: rsdc_sel_of = 8'h20;
        `RSDC_ADDR_WINDOW_CTRL: rsdc_sel_of = 8'h40;
        `RSDC_ADDR_LOSS_CTRL: rsdc_sel_of = 8'h80;
        default: rsdc_sel_of = 8'h00;
      endcase
    end
  endfunction

  function [7:0] rsdc_rst_of;
    input integer idx;
    begin
      case (idx)
        IDX_OCTAVE: rsdc_rst_of = `RSDC_RST_OCTAVE;
        IDX_MAIN_HIGH: rsdc_rst_of = `RSDC_RST_MAIN_HIGH;
        IDX_MAIN_LOW: rsdc_rst_of = `RSDC_RST_MAIN_LOW;
        IDX_FRAC_UPPER: rsdc_rst_of = `RSDC_RST_FRAC_UPPER;
        IDX_FRAC_MIDDLE: rsdc_rst_of = `RSDC_RST_FRAC_MIDDLE;
        IDX_FRAC_LOWER: rsdc_rst_of = `RSDC_RST_FRAC_LOWER;
        IDX_WINDOW_CTRL: rsdc_rst_of = `RSDC_RST_WINDOW_CTRL;
        IDX_LOSS_CTRL: rsdc_rst_of = `RSDC_RST_LOSS_CTRL;
        default: rsdc_rst_of = 8'h00;
      endcase
    end
  endfunction

  // reserved bits are cleared on write so they always read zero
  function [7:0] rsdc_mask_of;
    input integer idx;
    begin
      case (idx)
        IDX_OCTAVE: rsdc_mask_of = `RSDC_MASK_OCTAVE;
        IDX_MAIN_HIGH: rsdc_mask_of = `RSDC_MASK_MAIN_HIGH;
        IDX_MAIN_LOW: rsdc_mask_of = 8'hFF;
        IDX_FRAC_UPPER: rsdc_mask_of = `RSDC_MASK_FRAC_UPPER;
        IDX_FRAC_MIDDLE: rsdc_mask_of = 8'hFF;
        IDX_FRAC_LOWER: rsdc_mask_of = 8'hFF;
        IDX_WINDOW_CTRL: rsdc_mask_of = `RSDC_MASK_WINDOW_CTRL;
        IDX_LOSS_CTRL: rsdc_mask_of = `RSDC_MASK_LOSS_CTRL;
        default: rsdc_mask_of = 8'h00;
      endcase
    end
  endfunction

  // undefined size codes map to zero ppm rather than guessing a width
  function [11:0] rsdc_ppm_of;
    input [2:0] code;
    begin
      case (code)
        `RSDC_WIN_2000PPM: rsdc_ppm_of = `RSDC_PPM_2000;
        `RSDC_WIN_1000PPM: rsdc_ppm_of = `RSDC_PPM_1000;
        `RSDC_WIN_500PPM: rsdc_ppm_of = `RSDC_PPM_500;
        `RSDC_WIN_250PPM: rsdc_ppm_of = `RSDC_PPM_250;
        default: rsdc_ppm_of = `RSDC_PPM_ZERO;
      endcase
    end
  endfunction

  assign addr_sel = rsdc_sel_of(reg_addr);
  assign wr_sel = reg_wr_en ? addr_sel : {REG_COUNT{1'b0}};
  assign rd_sel = reg_rd_en ? addr_sel : {REG_COUNT{1'b0}};

  // same storage cell for every byte; only reset value and mask differ
  genvar gi;
  generate
    for (gi = 0; gi < REG_COUNT; gi = gi + 1) begin : g_bank
      localparam [7:0] RST_VAL = rsdc_rst_of(gi);
      localparam [7:0] KEEP_MASK = rsdc_mask_of(gi);
      reg [7:0] byte_q;
      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          byte_q <= RST_VAL;
        end else if (wr_sel[gi]) begin
          byte_q <= reg_wr_data & KEEP_MASK;
        end
      end
      assign bank_flat[gi*8 +: 8] = byte_q;
    end
  endgenerate

  assign octave_byte = bank_flat[IDX_OCTAVE*8 +: 8];
  assign main_high_byte = bank_flat[IDX_MAIN_HIGH*8 +: 8];
  assign main_low_byte = bank_flat[IDX_MAIN_LOW*8 +: 8];
  assign frac_upper_byte = bank_flat[IDX_FRAC_UPPER*8 +: 8];
  assign frac_middle_byte = bank_flat[IDX_FRAC_MIDDLE*8 +: 8];
  assign frac_lower_byte = bank_flat[IDX_FRAC_LOWER*8 +: 8];
  assign window_ctrl_byte = bank_flat[IDX_WINDOW_CTRL*8 +: 8];
  assign loss_ctrl_byte = bank_flat[IDX_LOSS_CTRL*8 +: 8];

  assign octave_ratio_code = octave_byte[2:0];
  assign main_ratio_top_bit = main_high_byte[0];
  assign main_ratio_low_byte = main_low_byte;
  assign fraction_upper_bits = frac_upper_byte[5:0];
  assign fraction_middle_bits = frac_middle_byte;
  assign fraction_lower_bits = frac_lower_byte;
  assign integer_only_select = frac_upper_byte[`RSDC_BIT_INTEGER_ONLY];
  assign window_size_code = window_ctrl_byte[2:0];
  assign manual_window_select = window_ctrl_byte[`RSDC_BIT_MANUAL_WINDOW];
  assign window_control_source = window_ctrl_byte[`RSDC_BIT_WINDOW_SOURCE];
  assign auto_window_field = window_ctrl_byte[`RSDC_BIT_AUTO_WINDOW];
  assign loss_enable_field = loss_ctrl_byte[`RSDC_BIT_LOSS_ENABLE];

  // read mux; unmapped addresses answer zero with no hit
  always @* begin
    rd_data_d = 8'h00;
    rd_hit_d = 1'b0;
    for (ri = 0; ri < REG_COUNT; ri = ri + 1) begin
      if (rd_sel[ri]) begin
        rd_data_d = bank_flat[ri*8 +: 8];
        rd_hit_d = 1'b1;
      end
    end
  end

  // data holds until the next read so a slow host can pick it up late
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rd_data <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rd_data <= rd_data_d;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rd_hit <= 1'b0;
    end else begin
      reg_rd_hit <= rd_hit_d;
    end
  end

  always @* begin
    if (window_control_source) begin
      mode_sel = manual_window_select;
    end else begin
      mode_sel = window_select_pin;
    end
  end

  // code 111 is undefined; it is held at the largest ratio
  always @* begin
    case (octave_ratio_code)
      3'h7: octave_ratio_d = OCTAVE_RATIO_MAX;
      default: octave_ratio_d = OCTAVE_RATIO_RST << octave_ratio_code;
    endcase
  end

  always @* begin
    main_ratio_d = {main_ratio_top_bit, main_ratio_low_byte};
  end

  // forced to zero so the divider never sees a stale fraction in integer mode
  always @* begin
    if (integer_only_select) begin
      fraction_value_d = 22'h000000;
    end else begin
      fraction_value_d = {fraction_upper_bits, fraction_middle_bits, fraction_lower_bits};
    end
  end

  always @* begin
    if (mode_sel) begin
      window_ppm_d = rsdc_ppm_of(window_size_code);
    end else begin
      window_ppm_d = `RSDC_PPM_ZERO;
    end
  end

  // decoded settings registered so the analog side sees glitch-free levels
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      octave_ratio <= OCTAVE_RATIO_RST;
    end else begin
      octave_ratio <= octave_ratio_d;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      main_ratio <= MAIN_RATIO_RST;
    end else begin
      main_ratio <= main_ratio_d;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fraction_value <= 22'h000000;
      no_fraction_flag <= 1'b1;
    end else begin
      fraction_value <= fraction_value_d;
      no_fraction_flag <= integer_only_select;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      window_ppm <= `RSDC_PPM_ZERO;
      window_manual_active <= 1'b0;
    end else begin
      window_ppm <= window_ppm_d;
      window_manual_active <= mode_sel;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      auto_window_enable <= 1'b0;
      signal_loss_detect_enable <= 1'b1;
    end else begin
      auto_window_enable <= auto_window_field;
      signal_loss_detect_enable <= loss_enable_field;
    end
  end

endmodule
`default_nettype wire

// file: test/rsdc_host.sv
// host model for the config bank strobes
`timescale 1ns/1ns
`default_nettype none
module rsdc_host (
  input wire core_clk, input wire [7:0] reg_rd_data, input wire reg_rd_hit,
  output logic reg_wr_en = 0, output logic reg_rd_en = 0,
  output logic [7:0] reg_addr = 0, output logic [7:0] reg_wr_data = 0
);
  // callers keep reserved bits zero and codes defined
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) #1 {reg_wr_en, reg_addr, reg_wr_data} = {1'b1, a, d};
    @(posedge core_clk) #1 {reg_wr_en, reg_addr, reg_wr_data} = {1'b0, ~a, ~d};
    @(posedge core_clk) #1;
  endtask
  task rd(input logic [7:0] a, output logic [8:0] q);
    @(posedge core_clk) #1 {reg_rd_en, reg_addr} = {1'b1, a};
    @(posedge core_clk) #1 {reg_rd_en, reg_addr} = {1'b0, ~a};
    q = {reg_rd_hit, reg_rd_data};
  endtask
endmodule
`default_nettype wire

// file: test/rsdc_props.sv
// port assertions of the config bank
`timescale 1ns/1ns
`default_nettype none
module rsdc_props (
  input wire core_clk, input wire rst, input wire reg_wr_en, input wire reg_rd_en,
  input wire [7:0] reg_addr, input wire [7:0] reg_wr_data, input wire reg_rd_hit,
  input wire [6:0] octave_ratio, input wire [8:0] main_ratio, input wire [21:0] fraction_value,
  input wire no_fraction_flag, input wire [11:0] window_ppm, input wire window_manual_active,
  input wire auto_window_enable, input wire signal_loss_detect_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire [7:0] a = reg_addr;
  wire [7:0] d = reg_wr_data;
  wire hit = a >= 8'hC0 && a <= 8'hC6 || a == 8'hD1;
  octave_map_a: assert property (reg_wr_en && a == 8'hC0 && d[2:0] != 3'h7 |=> ##1
    octave_ratio == 7'h01 << ($past(d, 2) & 8'h07)) else $error("octave ratio wrong");
  main_top_a: assert property (reg_wr_en && a == 8'hC1 |=> ##1
    main_ratio[8] == $past(d[0], 2)) else $error("main ratio top bit wrong");
  frac_low_a: assert property (reg_wr_en && a == 8'hC5 && !no_fraction_flag |=> ##1
    fraction_value[7:0] == $past(d, 2)) else $error("fraction low byte wrong");
  int_only_a: assert property (no_fraction_flag |-> fraction_value == 22'h0)
    else $error("fraction not zero");
  window_off_a: assert property (!window_manual_active |-> window_ppm == 12'h0)
    else $error("window not zero");
  auto_win_a: assert property (reg_wr_en && a == 8'hC6 |=> ##1
    auto_window_enable == $past(d[5], 2)) else $error("auto window wrong");
  loss_en_a: assert property (reg_wr_en && a == 8'hD1 |=> ##1
    signal_loss_detect_enable == $past(d[0], 2)) else $error("loss enable wrong");
  read_hit_a: assert property (reg_rd_en |=> reg_rd_hit == $past(hit))
    else $error("read hit wrong");
endmodule
bind rsdc_config_regs rsdc_props i_rsdc_props (.*);
`default_nettype wire

// file: test/tb.sv
// self-checking bench of the config bank
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic core_clk = 0, rst = 1, window_select_pin = 0;
  wire reg_wr_en, reg_rd_en, reg_rd_hit, no_fraction_flag, window_manual_active;
  wire auto_window_enable, signal_loss_detect_enable;
  wire [7:0] reg_addr, reg_wr_data, reg_rd_data;
  wire [6:0] octave_ratio;
  wire [8:0] main_ratio;
  wire [21:0] fraction_value;
  wire [11:0] window_ppm;
  logic [8:0] q;
  int mismatches = 0, checked = 0;
  logic [7:0] rv [8] = '{8'h00, 8'h01, 8'h00, 8'h80, 8'h00, 8'h00, 8'h0C, 8'h0D};
  logic [11:0] ppm [4] = '{12'h7D0, 12'h3E8, 12'h1F4, 12'h0FA};
  rsdc_host i_rsdc_host (.*);
  rsdc_config_regs i_rsdc_config_regs (.*);
  task cmp(input string n, input logic [21:0] e, input logic [21:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task wrap_up;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial forever #20 core_clk = ~core_clk;
  initial begin
    #100000 mismatches++;
    wrap_up;
  end
  initial begin
    repeat (2) @(posedge core_clk);
    #1 rst = 0;
    for (int i = 0; i < 8; i++) begin
      i_rsdc_host.rd(8'(i == 7 ? 8'hD1 : 8'hC0 + i), q);
      cmp("reset value", {13'h1, rv[i]}, q);
    end
    i_rsdc_host.rd(8'hD0, q);
    cmp("unmapped read", 22'h0, q);
    cmp("main ratio", 22'h100, main_ratio);
    cmp("no fraction", 22'h1, no_fraction_flag);
    cmp("pin mode", 22'h0, window_manual_active);
    $display("reset test done");
    for (int c = 0; c < 7; c++) begin
      i_rsdc_host.wr(8'hC0, 8'(c));
      cmp("octave ratio", 22'(7'h01 << c), octave_ratio);
    end
    i_rsdc_host.wr(8'hC2, 8'h5A);
    i_rsdc_host.wr(8'hC1, 8'h00);
    cmp("main ratio", 22'h05A, main_ratio);
    i_rsdc_host.wr(8'hC3, 8'h25);
    i_rsdc_host.wr(8'hC4, 8'hC3);
    i_rsdc_host.wr(8'hC5, 8'h7E);
    cmp("fraction", 22'h25C37E, fraction_value);
    i_rsdc_host.rd(8'hC5, q);
    cmp("fraction readback", 22'h17E, q);
    i_rsdc_host.wr(8'hC3, 8'hA5);
    cmp("no fraction", 22'h1, no_fraction_flag);
    $display("divider test done");
    #40 window_select_pin = 1;
    #80 cmp("pin window", 22'h3E8, window_ppm);
    cmp("pin mode", 22'h1, window_manual_active);
    for (int k = 0; k < 4; k++) begin
      i_rsdc_host.wr(8'hC6, 8'(8'h1B + k));
      cmp("window ppm", 22'(ppm[k]), window_ppm);
    end
    // register source with manual off must beat the high pin
    i_rsdc_host.wr(8'hC6, 8'h34);
    cmp("window off", 22'h0, window_ppm);
    cmp("manual mode", 22'h0, window_manual_active);
    cmp("auto window", 22'h1, auto_window_enable);
    i_rsdc_host.wr(8'hD1, 8'h0C);
    cmp("loss enable", 22'h0, signal_loss_detect_enable);
    $display("window test done");
    wrap_up;
  end
endmodule
`default_nettype wire
